// *** bench/remote_link_model.sv ***
// far-side model: remote serializer config loads and the pulled-up local clock wire
`timescale 1ns/1ps
module remote_link_model
(
  input  wire logic       clk,
  input  wire logic       send,
  input  wire logic [7:0] send_cfg,
  input  wire logic       scl_o,
  input  wire logic       scl_drive_n,
  output logic            fc_load,
  output logic      [7:0] fc_config,
  output logic            scl_i
);
  // pull-up on the clock wire: released reads high
  assign scl_i = scl_drive_n ? 1'b1 : scl_o;
  initial
  begin
    fc_load   = 1'b0;
    fc_config = 8'hA5;
  end
  // the byte means something only with the strobe; between loads it toggles
  always @(posedge clk)
  begin
    fc_load   <= send;
    fc_config <= send ? send_cfg : ~fc_config;
  end
endmodule

// *** bench/tb_deser_i2c_timing_datapath_regs.sv ***
// self-checking bench for the timing, datapath and audio control register slice
`timescale 1ns/1ps
module tb_deser_i2c_timing_datapath_regs
  import deser_regs_pkg::*;
;
  logic       clk;
  logic       reset;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, fc_config, send_cfg, v;
  logic       reg_we, reg_re, reg_rvalid, fc_load, send, master_en, slave_setup_req;
  logic       slave_sda_bit, scl_i, scl_o, scl_drive_n, sda_o, sda_drive_n;
  logic       aud_overrun_ev, aud_underrun_ev, audio_word_clk, audio_data;
  logic       general_pin_zero_in, general_pin_one_in, remote_dual_detected;
  logic       general_pin_zero, general_pin_one, audio_out_en, audio_strobe_rising;
  logic       audio_surround_en, wide_video_with_syncs, video_absent, dual_link_rx;
  logic [1:0] receive_input_mode;
  logic [7:0] exp_q[$];
  logic [7:0] exp_v;
  integer     seed = 32'h8BF8;
  integer     mismatches = 0;
  integer     cmp_count = 0;
  integer     cycles = 0;
  integer     n;

  deser_timing_datapath_regs deser_timing_datapath_regs_inst (
    .clk, .reset, .reg_addr, .reg_wdata, .reg_we, .reg_re, .reg_rdata, .reg_rvalid,
    .fc_load, .fc_config, .master_en, .slave_setup_req, .slave_sda_bit, .scl_i, .scl_o,
    .scl_drive_n, .sda_o, .sda_drive_n, .aud_overrun_ev, .aud_underrun_ev,
    .audio_word_clk, .audio_data, .general_pin_zero_in, .general_pin_one_in,
    .remote_dual_detected, .general_pin_zero, .general_pin_one, .audio_out_en,
    .audio_strobe_rising, .audio_surround_en, .wide_video_with_syncs, .video_absent,
    .dual_link_rx, .receive_input_mode);

  remote_link_model remote_link_model_inst (
    .clk, .send, .send_cfg, .scl_o, .scl_drive_n, .fc_load, .fc_config, .scl_i);

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // --------------------------------
  // tasks
  // --------------------------------
  task automatic close_out;
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] e);
    cmp_count = cmp_count + 1;
    if (got !== e)
    begin
      mismatches = mismatches + 1;
      $display("[ERR] %0t pin %h expected %h", $time, got, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_we    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_we    <= 1'b0;
  endtask

  // the expected value is queued here and taken off by the read monitor
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge clk);
    reg_re   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_re   <= 1'b0;
  endtask

  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask

  task automatic fire(input logic [7:0] cfg);
    @(posedge clk);
    send     <= 1'b1;
    send_cfg <= cfg;
    @(posedge clk);
    send     <= 1'b0;
  endtask

  task automatic ev(input logic ovr);
    @(posedge clk);
    aud_overrun_ev  <= ovr;
    aud_underrun_ev <= ~ovr;
    @(posedge clk);
    aud_overrun_ev  <= 1'b0;
    aud_underrun_ev <= 1'b0;
  endtask

  // tick period is fractional, so a span of n units may land a few cycles either side
  task automatic span(input logic lvl, input int n);
    int c;
    c = 0;
    while (scl_drive_n === lvl && c < 4000)
    begin
      @(posedge clk);
      #1;
      c = c + 1;
    end
    if (n > 0)
    begin
      cmp_count = cmp_count + 1;
      if (c < 5 * n / 2 - 2 || c > 5 * n / 2 + 4)
      begin
        mismatches = mismatches + 1;
        $display("[ERR] %0t level %b held %0d cycles for %0d units", $time, lvl, c, n);
      end
    end
  endtask

  always @(posedge clk)
    if (reg_rvalid === 1'b1)
    begin
      cmp_count = cmp_count + 1;
      exp_v = 8'hXX;
      if (exp_q.size() != 0)
        exp_v = exp_q.pop_front();
      if (reg_rdata !== exp_v)
      begin
        mismatches = mismatches + 1;
        $display("[ERR] %0t read %h expected %h", $time, reg_rdata, exp_v);
      end
    end

  always @(posedge clk)
  begin
    cycles = cycles + 1;
    if (cycles == 20000)
    begin
      mismatches = mismatches + 1;
      $display("[ERR] %0t run did not finish", $time);
      close_out();
    end
  end

  // --------------------------------
  // scenarios
  // --------------------------------
  initial
  begin
    reset = 1'b1;
    {reg_we, reg_re, send, master_en, slave_setup_req, slave_sda_bit} = '0;
    {aud_overrun_ev, aud_underrun_ev, audio_word_clk, audio_data} = '0;
    {general_pin_zero_in, general_pin_one_in, remote_dual_detected} = '0;
    {reg_addr, reg_wdata, send_cfg} = '0;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    #1;
    chk(audio_out_en, 1'b1);
    chk(scl_drive_n, 1'b1);
    rd(OFS_CLK_HIGH, RST_CLK_HIGH);
    rd(OFS_CLK_LOW, RST_CLK_LOW);
    rd(OFS_DATAPATH, RST_DATAPATH);
    rd(OFS_AUDIO_CTL, RST_AUDIO_CTL);
    rd(OFS_INPUT_MODE, 8'h00);
    wr(8'h29, 8'hFF);
    rd(8'h29, 8'h00);
    $display("test reset values done");
    for (n = 0; n < 3; n = n + 1)
    begin
      v = 8'($random(seed));
      wr(OFS_CLK_HIGH, v);
      rd(OFS_CLK_HIGH, v);
      wr(OFS_CLK_LOW, ~v);
      rd(OFS_CLK_LOW, ~v);
    end
    $display("test count registers done");
    for (n = 0; n < 4; n = n + 1)
    begin
      v = 8'($random(seed));
      fire(v);
      rd(OFS_DATAPATH, {2'b00, v[5:0]});
      settle();
      chk(video_absent, v[5]);
      chk(wide_video_with_syncs, v[1]);
      chk(audio_surround_en, v[0]);
      chk(audio_out_en, !v[2]);
    end
    wr(OFS_DATAPATH, 8'hA0);
    fire(8'h1F);
    rd(OFS_DATAPATH, 8'hA0);
    settle();
    chk(video_absent, 1'b1);
    $display("test remote load done");
    for (n = 0; n < 2; n = n + 1)
    begin
      wr(OFS_DATAPATH, n[0] ? 8'h28 : 8'h20);
      repeat (3)
      begin
        @(posedge clk);
        {audio_word_clk, audio_data, general_pin_one_in, general_pin_zero_in} <=
          4'($random(seed));
        settle();
        chk(general_pin_one, n[0] ? audio_word_clk : general_pin_one_in);
        chk(general_pin_zero, n[0] ? audio_data : general_pin_zero_in);
      end
    end
    $display("test alternate audio done");
    for (n = 0; n < 16; n = n + 1)
    begin
      wr(OFS_DATAPATH, {3'b000, n[2], 4'h0});
      wr(OFS_INPUT_MODE, {3'b000, n[1:0], 3'b000});
      remote_dual_detected <= n[3];
      settle();
      rd(OFS_INPUT_MODE, {3'b000, n[1:0], 3'b000});
      chk(receive_input_mode, n[1:0]);
      chk(dual_link_rx, n[1:0] == 2'h1 || (n[1:0] == 2'h0 && n[2] && n[3]));
    end
    $display("test input mode done");
    wr(OFS_AUDIO_CTL, 8'h01);
    ev(1'b1);
    repeat (6) @(posedge clk);
    rd(OFS_AUDIO_CTL, 8'h09);
    ev(1'b0);
    rd(OFS_AUDIO_CTL, 8'h0D);
    settle();
    chk(audio_strobe_rising, 1'b1);
    wr(OFS_AUDIO_CTL, 8'h03);
    rd(OFS_AUDIO_CTL, 8'h01);
    wr(OFS_AUDIO_CTL, 8'h0C);
    rd(OFS_AUDIO_CTL, 8'h00);
    settle();
    chk(audio_strobe_rising, 1'b0);
    // an overrun in the same cycle as the clear must survive it
    @(posedge clk);
    reg_we         <= 1'b1;
    reg_addr       <= OFS_AUDIO_CTL;
    reg_wdata      <= 8'h02;
    aud_overrun_ev <= 1'b1;
    @(posedge clk);
    reg_we         <= 1'b0;
    aud_overrun_ev <= 1'b0;
    rd(OFS_AUDIO_CTL, 8'h08);
    $display("test audio status done");
    for (n = 0; n < 2; n = n + 1)
    begin
      v = 8'h04 + 8'($random(seed) & 7);
      wr(OFS_CLK_LOW, v);
      @(posedge clk);
      slave_setup_req <= 1'b1;
      slave_sda_bit   <= n[0];
      @(posedge clk);
      slave_setup_req <= 1'b0;
      @(posedge clk);
      #1;
      chk(scl_drive_n, 1'b0);
      chk(sda_drive_n, 1'b0);
      chk(sda_o, n[0]);
      chk(scl_o, 1'b0);
      span(1'b0, v);
      chk(sda_drive_n, 1'b1);
    end
    $display("test slave setup done");
    v = 8'h04 + 8'($random(seed) & 7);
    wr(OFS_CLK_HIGH, v);
    wr(OFS_CLK_LOW, v + 8'h03);
    @(posedge clk);
    master_en <= 1'b1;
    @(posedge clk);
    #1;
    span(1'b1, 0);
    span(1'b0, v + 3);
    span(1'b1, v);
    @(posedge clk);
    master_en <= 1'b0;
    #1;
    span(1'b0, 0);
    repeat (40) @(posedge clk);
    #1;
    chk(scl_drive_n, 1'b1);
    $display("test master clock done");
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    rd(OFS_CLK_HIGH, RST_CLK_HIGH);
    rd(OFS_CLK_LOW, RST_CLK_LOW);
    repeat (4) @(posedge clk);
    $display("test second reset done");
    close_out();
  end
endmodule

// *** design/deser_regs_pkg.sv ***
// constants, types and register map of the deserializer timing and datapath register slice
package deser_regs_pkg;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CLK_HIGH   = 8'h26;
  localparam logic [7:0] OFS_CLK_LOW    = 8'h27;
  localparam logic [7:0] OFS_DATAPATH   = 8'h28;
  localparam logic [7:0] OFS_AUDIO_CTL  = 8'h2B;
  localparam logic [7:0] OFS_INPUT_MODE = 8'h34;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_CLK_HIGH  = 8'h83;
  localparam logic [7:0] RST_CLK_LOW   = 8'h84;
  localparam logic [7:0] RST_DATAPATH  = 8'h00;
  localparam logic [7:0] RST_AUDIO_CTL = 8'h00;
  localparam logic [1:0] RST_MODE      = 2'h0;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int AUD_OVERRUN_BIT  = 3;
  localparam int AUD_UNDERRUN_BIT = 2;
  localparam int AUD_ERR_CLR_BIT  = 1;
  localparam int AUD_RISE_BIT     = 0;
  localparam int MODE_LSB         = 3;
  localparam int FC_LOADED_BITS   = 6;

  // input mode encodings
  localparam logic [1:0] MODE_AUTO     = 2'h0;
  localparam logic [1:0] MODE_DUAL     = 2'h1;
  localparam logic [1:0] MODE_PRIMARY  = 2'h2;
  localparam logic [1:0] MODE_SECOND   = 2'h3;

  // ---------------------------------------------------------------
  // timing: one count of the pulse-width fields, and the clock period
  // ---------------------------------------------------------------
  localparam int UNIT_NS       = 50;
  localparam int CLK_PERIOD_NS = 20;

  // datapath configuration register, bit 7 down to bit 0
  typedef struct packed {
    logic block_remote_config_load;
    logic spare;
    logic video_absent;
    logic dual_link;
    logic alt_audio;
    logic audio_off;
    logic wide_video_with_syncs;
    logic surround;
  } dp_cfg_s;

  typedef enum logic [2:0] {PH_IDLE, PH_RISE, PH_HIGH, PH_LOW, PH_SETUP} phase_e;

  typedef struct packed {
    logic [7:0] cnt;
    logic       busy;
    logic       done;
  } timer_state_s;

  typedef struct packed {
    phase_e     ph;
    logic [6:0] acc;
    logic       tick;
    logic [7:0] hi;
    logic [7:0] lo;
    dp_cfg_s    dp;
    logic [1:0] mode;
    logic [3:0] aud_spare;
    logic       ovr;
    logic       udr;
    logic       edge_rise;
    logic [7:0] rdata;
    logic       rvalid;
    logic       scl_lvl;
    logic       scl_drive_n;
    logic       sda_o;
    logic       sda_drive_n;
    logic       dual_rx;
    logic       pin0;
    logic       pin1;
    logic       audio_en;
  } main_state_s;

endpackage

// *** design/deser_timing_datapath_regs.sv ***
// timing, datapath configuration and audio control register slice of the deserializer
//
// Contract
// - as bus master, clock high lasts high count times 50 ns.
// - high count resets to 83h, at least 5 us even at 26 MHz.
// - as bus master, clock low lasts low count times 50 ns.
// - as slave, present data for low count before releasing the stretched clock.
// - low count resets to 84h, at least 5 us even at 26 MHz.
// - datapath bit 7 set blocks remote loading; clear allows it.
// - bit 5 reports video absent as loaded; control and pins still work.
// - bit 4 reports remote dual or single link, used in automatic mode.
// - while blocked, video-absent and link-count bits stay frozen.
// - dual-link reception is forced only by the input-mode field.
// - bit 3 routes alternate audio: word clock on pin one, data on zero.
// - bit 2 set disables the audio serial output.
// - bit 1 set means forward channel carries 28-bit video with syncs.
// - bit 0 set enables surround audio output.
// - audio control bit 3 reports overrun, bit 2 underrun, both read-only.
// - writing 1 to audio control bit 1 clears the recorded fifo errors.
// - audio control bit 0 selects rising (1) or falling (0) data strobe.
// - input mode: 00 auto, 01 dual, 10 single primary, 11 single secondary.
`timescale 1ns/1ps
module deser_timing_datapath_regs
  import deser_regs_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset,
  // register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_we,
  input  wire logic       reg_re,
  output logic      [7:0] reg_rdata,
  output logic            reg_rvalid,
  // forward channel configuration
  input  wire logic       fc_load,
  input  wire logic [7:0] fc_config,
  // local two-wire bus
  input  wire logic       master_en,
  input  wire logic       slave_setup_req,
  input  wire logic       slave_sda_bit,
  input  wire logic       scl_i,
  output logic            scl_o,
  output logic            scl_drive_n,
  output logic            sda_o,
  output logic            sda_drive_n,
  // audio, general pins and datapath effects
  input  wire logic       aud_overrun_ev,
  input  wire logic       aud_underrun_ev,
  input  wire logic       audio_word_clk,
  input  wire logic       audio_data,
  input  wire logic       general_pin_zero_in,
  input  wire logic       general_pin_one_in,
  input  wire logic       remote_dual_detected,
  output logic            general_pin_zero,
  output logic            general_pin_one,
  output logic            audio_out_en,
  output logic            audio_strobe_rising,
  output logic            audio_surround_en,
  output logic            wide_video_with_syncs,
  output logic            video_absent,
  output logic            dual_link_rx,
  output logic      [1:0] receive_input_mode
);

  initial
  begin
    if (CLK_PERIOD_NS >= UNIT_NS)
      $error("clock too slow for the 50 ns pulse-width unit");
  end

  main_state_s r;
  main_state_s nx;
  logic        tmr_load;
  logic [7:0]  tmr_count;
  logic        tmr_busy;
  logic        tmr_done;
  logic        wr_hi;
  logic        wr_lo;
  logic        wr_dp;
  logic        wr_aud;
  logic        wr_mode;
  logic        err_clear;
  logic [7:0]  acc_sum;

  assign wr_hi     = reg_we && (reg_addr == OFS_CLK_HIGH);
  assign wr_lo     = reg_we && (reg_addr == OFS_CLK_LOW);
  assign wr_dp     = reg_we && (reg_addr == OFS_DATAPATH);
  assign wr_aud    = reg_we && (reg_addr == OFS_AUDIO_CTL);
  assign wr_mode   = reg_we && (reg_addr == OFS_INPUT_MODE);
  assign err_clear = wr_aud && reg_wdata[AUD_ERR_CLR_BIT];

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    nx        = r;
    tmr_load  = 1'b0;
    tmr_count = r.hi;

    // fractional divider: 2.5 clocks per unit, alternating 2 and 3 cycles
    acc_sum = {1'b0, r.acc} + 8'(CLK_PERIOD_NS);
    nx.tick = 1'b0;
    if (acc_sum >= 8'(UNIT_NS))
    begin
      nx.acc  = 7'(acc_sum - 8'(UNIT_NS));
      nx.tick = 1'b1;
    end
    else
      nx.acc = acc_sum[6:0];

    // register writes
    if (wr_hi)
      nx.hi = reg_wdata;
    if (wr_lo)
      nx.lo = reg_wdata;
    if (wr_mode)
      nx.mode = reg_wdata[MODE_LSB+1:MODE_LSB];
    if (wr_aud)
    begin
      nx.aud_spare = reg_wdata[7:4];
      nx.edge_rise = reg_wdata[AUD_RISE_BIT];
    end

    // a local write wins over a remote load arriving in the same cycle
    if (wr_dp)
      nx.dp = dp_cfg_s'(reg_wdata);
    else if (fc_load && !r.dp.block_remote_config_load)
      nx.dp[FC_LOADED_BITS-1:0] = fc_config[FC_LOADED_BITS-1:0];

    // sticky fifo errors; a new event beats a clear in the same cycle
    if (err_clear)
    begin
      nx.ovr = 1'b0;
      nx.udr = 1'b0;
    end
    if (aud_overrun_ev)
      nx.ovr = 1'b1;
    if (aud_underrun_ev)
      nx.udr = 1'b1;

    // read path, one cycle after the strobe
    nx.rvalid = reg_re;
    nx.rdata  = 8'h00;
    if (reg_re)
    begin
      unique case (reg_addr)
        OFS_CLK_HIGH:   nx.rdata = r.hi;
        OFS_CLK_LOW:    nx.rdata = r.lo;
        OFS_DATAPATH:   nx.rdata = r.dp;
        OFS_AUDIO_CTL:  nx.rdata = {r.aud_spare, r.ovr, r.udr, 1'b0, r.edge_rise};
        OFS_INPUT_MODE: nx.rdata = 8'({r.mode, 3'b000});
        default:        nx.rdata = 8'h00;
      endcase
    end

    // ---------------------------------------------------------------
    // clock pulse shaping
    // ---------------------------------------------------------------
    unique case (r.ph)
      PH_IDLE:
      begin
        if (slave_setup_req)
        begin
          nx.ph     = PH_SETUP;
          tmr_load  = 1'b1;
          tmr_count = r.lo;
        end
        else if (master_en)
          nx.ph = PH_RISE;
      end
      PH_RISE:
      begin
        // wait for the wire to rise in case another party holds it low
        if (scl_i)
        begin
          nx.ph     = PH_HIGH;
          tmr_load  = 1'b1;
          tmr_count = r.hi;
        end
      end
      PH_HIGH:
      begin
        if (tmr_done)
        begin
          nx.ph     = PH_LOW;
          tmr_load  = 1'b1;
          tmr_count = r.lo;
        end
      end
      PH_LOW:
      begin
        if (tmr_done)
          nx.ph = master_en ? PH_RISE : PH_IDLE;
      end
      PH_SETUP:
      begin
        if (tmr_done)
          nx.ph = PH_IDLE;
      end
      default:
        nx.ph = PH_IDLE;
    endcase

    nx.scl_lvl     = 1'b0;
    nx.scl_drive_n = !(nx.ph == PH_LOW || nx.ph == PH_SETUP);
    nx.sda_drive_n = !(nx.ph == PH_SETUP);
    if (r.ph == PH_IDLE && nx.ph == PH_SETUP)
      nx.sda_o = slave_sda_bit;

    // ---------------------------------------------------------------
    // datapath effects
    // ---------------------------------------------------------------
    // the link-count bit only steers automatic mode, never forces it
    unique case (nx.mode)
      MODE_AUTO:    nx.dual_rx = nx.dp.dual_link && remote_dual_detected;
      MODE_DUAL:    nx.dual_rx = 1'b1;
      MODE_PRIMARY: nx.dual_rx = 1'b0;
      MODE_SECOND:  nx.dual_rx = 1'b0;
    endcase

    // pins keep their own function unless alternate audio is routed
    nx.pin1     = nx.dp.alt_audio ? audio_word_clk : general_pin_one_in;
    nx.pin0     = nx.dp.alt_audio ? audio_data : general_pin_zero_in;
    nx.audio_en = !nx.dp.audio_off;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      r             <= '0;
      r.ph          <= PH_IDLE;
      r.hi          <= RST_CLK_HIGH;
      r.lo          <= RST_CLK_LOW;
      r.dp          <= dp_cfg_s'(RST_DATAPATH);
      r.mode        <= RST_MODE;
      r.scl_drive_n <= 1'b1;
      r.sda_drive_n <= 1'b1;
      r.audio_en    <= 1'b1;
    end
    else
      r <= nx;
  end

  pulse_width_timer #(
    .WIDTH (8)
  ) u_timer (
    .clk   (clk),
    .reset (reset),
    .tick  (r.tick),
    .load  (tmr_load),
    .count (tmr_count),
    .busy  (tmr_busy),
    .done  (tmr_done)
  );

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign reg_rdata             = r.rdata;
  assign reg_rvalid            = r.rvalid;
  assign scl_o                 = r.scl_lvl;
  assign scl_drive_n           = r.scl_drive_n;
  assign sda_o                 = r.sda_o;
  assign sda_drive_n           = r.sda_drive_n;
  assign general_pin_zero      = r.pin0;
  assign general_pin_one       = r.pin1;
  assign audio_out_en          = r.audio_en;
  assign audio_strobe_rising   = r.edge_rise;
  assign audio_surround_en     = r.dp.surround;
  assign wide_video_with_syncs = r.dp.wide_video_with_syncs;
  assign video_absent          = r.dp.video_absent;
  assign dual_link_rx          = r.dual_rx;
  assign receive_input_mode    = r.mode;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_high_start;
    r.ph == PH_RISE && scl_i;
  endsequence

  sequence s_high_release;
    r.ph == PH_HIGH && scl_drive_n;
  endsequence

  a_high_phase_run: assert property (s_high_start |=> s_high_release[*2])
    else $error("master clock not released through the high phase");
  a_low_phase_drive: assert property (r.ph == PH_HIGH && tmr_done |=> !scl_drive_n && tmr_busy)
    else $error("master clock not driven low after the high phase");
  a_slave_setup_hold: assert property (r.ph == PH_IDLE && slave_setup_req |=>
      !scl_drive_n && !sda_drive_n && sda_o == $past(slave_sda_bit))
    else $error("slave setup does not hold clock and present data");
  a_reset_counts: assert property ($fell(reset) |-> r.hi == 8'h83 && r.lo == 8'h84)
    else $error("pulse-width counts wrong after reset");
  a_remote_blocked: assert property (r.dp.block_remote_config_load && fc_load && !wr_dp |=>
      $stable(r.dp))
    else $error("blocked datapath register changed by remote load");
  a_remote_loads: assert property (!r.dp.block_remote_config_load && fc_load && !wr_dp |=>
      r.dp[5:0] == $past(fc_config[5:0]))
    else $error("remote load not taken");
  a_errors_sticky: assert property (aud_overrun_ev ##1 !err_clear[*3] |-> r.ovr)
    else $error("overrun status not held");
  a_errors_clear: assert property (err_clear && !aud_overrun_ev && !aud_underrun_ev |=>
      !r.ovr && !r.udr)
    else $error("fifo error clear ignored");
  a_error_set_wins: assert property ((aud_overrun_ev |=> r.ovr) and (aud_underrun_ev |=> r.udr))
    else $error("fifo error event lost");
  a_status_readback: assert property (reg_re && reg_addr == OFS_AUDIO_CTL |=>
      reg_rvalid && reg_rdata[3] == $past(r.ovr) && reg_rdata[2] == $past(r.udr))
    else $error("audio status read wrong");
  a_forced_dual: assert property (r.mode == MODE_DUAL && !wr_mode |=> dual_link_rx)
    else $error("forced dual mode not applied");
  a_alt_audio_route: assert property (r.dp.alt_audio && !wr_dp && !fc_load |=>
      general_pin_one == $past(audio_word_clk) && general_pin_zero == $past(audio_data))
    else $error("alternate audio not routed to the general pins");
  a_audio_disable: assert property (r.dp.audio_off && !wr_dp && !fc_load |=> !audio_out_en)
    else $error("audio output not disabled");

endmodule

// *** design/pulse_width_timer.sv ***
// counts a programmed number of time-unit ticks and pulses done at the end
`timescale 1ns/1ps
module pulse_width_timer
  import deser_regs_pkg::*;
#(
  parameter int WIDTH = 8
)(
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             tick,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] count,
  output logic                  busy,
  output logic                  done
);

  initial
  begin
    if (WIDTH != 8)
      $error("pulse_width_timer: WIDTH must be 8");
  end

  timer_state_s r;
  timer_state_s nx;
  logic [7:0]   seen_r;
  logic [7:0]   want_r;

  // ---------------------------------------------------------------
  // counter
  // ---------------------------------------------------------------
  always_comb
  begin
    nx      = r;
    nx.done = 1'b0;
    if (load)
    begin
      // a zero count still gives one unit, so the pin never glitches
      nx.cnt  = (count == 8'h00) ? 8'h01 : count;
      nx.busy = 1'b1;
    end
    else if (r.busy && tick)
    begin
      if (r.cnt == 8'h01)
      begin
        nx.busy = 1'b0;
        nx.done = 1'b1;
      end
      else
        nx.cnt = r.cnt - 8'h01;
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      r <= '0;
    else
      r <= nx;
  end

  assign busy = r.busy;
  assign done = r.done;

  // ---------------------------------------------------------------
  // checks: the phase lasts exactly the programmed number of units
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      seen_r <= 8'h00;
      want_r <= 8'h00;
    end
    else if (load)
    begin
      seen_r <= 8'h00;
      want_r <= (count == 8'h00) ? 8'h01 : count;
    end
    else if (r.busy && tick)
      seen_r <= seen_r + 8'h01;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_phase_unit_count: assert property ($rose(r.done) |-> seen_r == want_r)
    else $error("phase did not last the programmed count");
  a_timer_stops_once: assert property (r.done |-> !r.busy)
    else $error("timer still busy after done");

endmodule
